// ==== design/fbx_exec.sv ====
// flag branch, bit and shift execution unit with wishbone slave
//
// Operation
// [RQ1] taken flag branch loads pc+k+1; one cycle untaken, two taken
// [RQ2] carry-one and lower taken on carry one; carry-zero, same-or-higher on zero
// [RQ3] signed greater-or-equal taken when negative xor overflow is zero
// [RQ4] signed less-than on n xor v one; minus/plus test negative one/zero
// [RQ5] half-carry branches test half-carry one or zero, flags untouched
// [RQ6] transfer branches test transfer flag one or zero, flags untouched
// [RQ7] overflow branches test overflow one or zero, flags untouched
// [RQ8] interrupt branches test global interrupt flag one or zero
// [RQ9] io bit set/clear write the selected bit, two cycles, no flags
// [RQ10] logical shifts insert zero, one cycle, update z c n v
// [RQ11] rotates pass old carry in and shifted-out bit to carry
// [RQ12] arithmetic right shift keeps bit 7, updates z c n v
// [RQ13] nibble swap exchanges halves in one cycle, flags kept
// [RQ14] bit store copies selected bit to transfer flag only
// [RQ15] bit load copies transfer flag into selected bit, flags kept
// [RQ16] dedicated ops set or clear one named flag each in one cycle
// [RQ17] global interrupt on/off set or clear only the interrupt flag
// [RQ18] generic flag set/clear write status bit chosen by s
// [RQ19] generic flag branches test status bit s, jump by k+1
// [RQ20] io bit ops reach only addresses 0x00-0x1F, one bit only
// [RQ21] branch offset k is signed two's complement
`include "fbx_map.svh"

module fbx_exec #(
    parameter int PC_W = 16
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_ce,
    input  wire fbx_pkg::fbx_wb_req_s i_wb,
    output logic                      o_wb_ack,
    output logic [31:0]               o_wb_dat,
    output logic                      o_busy
);

    logic [7:0]             operand;
    logic [7:0]             flags;
    logic [PC_W-1:0]        pc;
    logic [7:0]             io_mem [0:31];
    logic [7:0]             last_cyc;
    logic                   io_err;
    fbx_pkg::fbx_instr_s    ir;
    fbx_pkg::fbx_state_e    state;
    fbx_pkg::fbx_state_e    next_state;
    logic                   req;
    logic                   sw_wr;
    logic                   start;
    logic                   io_hit;
    logic [31:0]            rd_data;
    logic [31:0]            wval;
    logic                   br;
    logic                   tk;
    logic [7:0]             res;
    logic [7:0]             nf;
    logic                   fe;
    logic [2:0]             fi;
    logic                   fv;
    logic                   io_op;
    logic                   io_val;
    logic                   io_bad;
    logic [PC_W-1:0]        br_target;

    function automatic logic [7:0] shf(input logic [7:0] f,
                                       input logic [7:0] r,
                                       input logic       c);
        logic [7:0] o;
        o = f;
        o[`FBX_FLAG_Z] = (r == 8'h00);
        o[`FBX_FLAG_C] = c;
        o[`FBX_FLAG_N] = r[7];
        o[`FBX_FLAG_V] = r[7] ^ c;
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave
    assign req    = i_wb.cyc & i_wb.stb & ~o_wb_ack;
    assign sw_wr  = req & i_wb.we & (state == fbx_pkg::st_idle);
    assign io_hit = i_wb.adr[`FBX_IO_SEL_BIT];
    assign start  = sw_wr & ~io_hit & (i_wb.adr == `FBX_OFF_INSTR);

    always_comb begin
        rd_data = 32'h0000_0000;
        if (io_hit) begin
            rd_data = {24'h00_0000, io_mem[i_wb.adr[6:2]]};
        end else begin
            case (i_wb.adr)
                `FBX_OFF_INSTR: rd_data = {9'h000, ir};
                `FBX_OFF_OPER:  rd_data = {24'h00_0000, operand};
                `FBX_OFF_FLAGS: rd_data = {24'h00_0000, flags};
                `FBX_OFF_PC:    rd_data = 32'(pc);
                `FBX_OFF_STAT:  rd_data = {16'h0000, last_cyc, 6'h00,
                                           io_err, o_busy};
                default:        rd_data = 32'h0000_0000;
            endcase
        end
    end

    // byte lanes merged over the current register contents
    always_comb begin
        wval = rd_data;
        for (int i = 0; i < 4; i++) begin
            if (i_wb.sel[i]) begin
                wval[i*8 +: 8] = i_wb.dat[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else if (i_ce) begin
            o_wb_ack <= req;
            if (req) begin
                o_wb_dat <= rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode and execute
    always_comb begin
        br     = 1'b0;
        tk     = 1'b0;
        res    = operand;
        nf     = flags;
        fe     = 1'b0;
        fi     = `FBX_FLAG_C;
        fv     = 1'b0;
        io_op  = 1'b0;
        io_val = 1'b0;
        unique case (ir.op)
            fbx_pkg::op_branch_carry_one,
            fbx_pkg::op_branch_lower:          {br, tk} = {1'b1, flags[`FBX_FLAG_C]}; // [RQ2]
            fbx_pkg::op_branch_carry_zero,
            fbx_pkg::op_branch_same_or_higher: {br, tk} = {1'b1, ~flags[`FBX_FLAG_C]}; // [RQ2]
            fbx_pkg::op_branch_negative_one:   {br, tk} = {1'b1, flags[`FBX_FLAG_N]}; // [RQ4]
            fbx_pkg::op_branch_negative_zero:  {br, tk} = {1'b1, ~flags[`FBX_FLAG_N]}; // [RQ4]
            fbx_pkg::op_branch_signed_ge:      {br, tk} = {1'b1, ~(flags[`FBX_FLAG_N] ^ flags[`FBX_FLAG_V])}; // [RQ3]
            fbx_pkg::op_branch_signed_lt:      {br, tk} = {1'b1, flags[`FBX_FLAG_N] ^ flags[`FBX_FLAG_V]}; // [RQ4]
            fbx_pkg::op_branch_halfcarry_one:  {br, tk} = {1'b1, flags[`FBX_FLAG_H]}; // [RQ5]
            fbx_pkg::op_branch_halfcarry_zero: {br, tk} = {1'b1, ~flags[`FBX_FLAG_H]}; // [RQ5]
            fbx_pkg::op_branch_transfer_one:   {br, tk} = {1'b1, flags[`FBX_FLAG_T]}; // [RQ6]
            fbx_pkg::op_branch_transfer_zero:  {br, tk} = {1'b1, ~flags[`FBX_FLAG_T]}; // [RQ6]
            fbx_pkg::op_branch_overflow_one:   {br, tk} = {1'b1, flags[`FBX_FLAG_V]}; // [RQ7]
            fbx_pkg::op_branch_overflow_zero:  {br, tk} = {1'b1, ~flags[`FBX_FLAG_V]}; // [RQ7]
            fbx_pkg::op_branch_irq_enabled:    {br, tk} = {1'b1, flags[`FBX_FLAG_I]}; // [RQ8]
            fbx_pkg::op_branch_irq_disabled:   {br, tk} = {1'b1, ~flags[`FBX_FLAG_I]}; // [RQ8]
            fbx_pkg::op_branch_flag_bit_one:   {br, tk} = {1'b1, flags[ir.sel]}; // [RQ19]
            fbx_pkg::op_branch_flag_bit_zero:  {br, tk} = {1'b1, ~flags[ir.sel]}; // [RQ19]
            fbx_pkg::op_io_bit_set:            {io_op, io_val} = 2'h3; // [RQ9]
            fbx_pkg::op_io_bit_clear:          {io_op, io_val} = 2'h2; // [RQ9]
            fbx_pkg::op_shift_left_logical: begin
                res = {operand[6:0], 1'b0}; // [RQ10]
                nf  = shf(flags, res, operand[7]);
            end
            fbx_pkg::op_shift_right_logical: begin
                res = {1'b0, operand[7:1]}; // [RQ10]
                nf  = shf(flags, res, operand[0]);
            end
            fbx_pkg::op_rotate_left_carry: begin
                res = {operand[6:0], flags[`FBX_FLAG_C]}; // [RQ11]
                nf  = shf(flags, res, operand[7]);
            end
            fbx_pkg::op_rotate_right_carry: begin
                res = {flags[`FBX_FLAG_C], operand[7:1]}; // [RQ11]
                nf  = shf(flags, res, operand[0]);
            end
            fbx_pkg::op_shift_right_arith: begin
                res = {operand[7], operand[7:1]}; // [RQ12]
                nf  = shf(flags, res, operand[0]);
            end
            fbx_pkg::op_swap_nibbles:     res = {operand[3:0], operand[7:4]}; // [RQ13]
            fbx_pkg::op_flag_bit_set:     {fe, fi, fv} = {1'b1, ir.sel, 1'b1}; // [RQ18]
            fbx_pkg::op_flag_bit_clear:   {fe, fi, fv} = {1'b1, ir.sel, 1'b0}; // [RQ18]
            fbx_pkg::op_reg_bit_to_transfer:
                {fe, fi, fv} = {1'b1, `FBX_FLAG_T, operand[ir.sel]}; // [RQ14]
            fbx_pkg::op_transfer_to_reg_bit: res[ir.sel] = flags[`FBX_FLAG_T]; // [RQ15]
            fbx_pkg::op_set_carry:        {fe, fi, fv} = {1'b1, `FBX_FLAG_C, 1'b1}; // [RQ16]
            fbx_pkg::op_clr_carry:        {fe, fi, fv} = {1'b1, `FBX_FLAG_C, 1'b0}; // [RQ16]
            fbx_pkg::op_set_negative:     {fe, fi, fv} = {1'b1, `FBX_FLAG_N, 1'b1}; // [RQ16]
            fbx_pkg::op_clr_negative:     {fe, fi, fv} = {1'b1, `FBX_FLAG_N, 1'b0}; // [RQ16]
            fbx_pkg::op_set_zero:         {fe, fi, fv} = {1'b1, `FBX_FLAG_Z, 1'b1}; // [RQ16]
            fbx_pkg::op_clr_zero:         {fe, fi, fv} = {1'b1, `FBX_FLAG_Z, 1'b0}; // [RQ16]
            fbx_pkg::op_set_sign:         {fe, fi, fv} = {1'b1, `FBX_FLAG_S, 1'b1}; // [RQ16]
            fbx_pkg::op_clr_sign:         {fe, fi, fv} = {1'b1, `FBX_FLAG_S, 1'b0}; // [RQ16]
            fbx_pkg::op_set_overflow:     {fe, fi, fv} = {1'b1, `FBX_FLAG_V, 1'b1}; // [RQ16]
            fbx_pkg::op_clr_overflow:     {fe, fi, fv} = {1'b1, `FBX_FLAG_V, 1'b0}; // [RQ16]
            fbx_pkg::op_set_transfer:     {fe, fi, fv} = {1'b1, `FBX_FLAG_T, 1'b1}; // [RQ16]
            fbx_pkg::op_clr_transfer:     {fe, fi, fv} = {1'b1, `FBX_FLAG_T, 1'b0}; // [RQ16]
            fbx_pkg::op_set_halfcarry:    {fe, fi, fv} = {1'b1, `FBX_FLAG_H, 1'b1}; // [RQ16]
            fbx_pkg::op_clr_halfcarry:    {fe, fi, fv} = {1'b1, `FBX_FLAG_H, 1'b0}; // [RQ16]
            fbx_pkg::op_irq_global_on:    {fe, fi, fv} = {1'b1, `FBX_FLAG_I, 1'b1}; // [RQ17]
            fbx_pkg::op_irq_global_off:   {fe, fi, fv} = {1'b1, `FBX_FLAG_I, 1'b0}; // [RQ17]
            default: ;
        endcase
        if (fe) begin
            nf[fi] = fv;
        end
    end

    assign io_bad    = ir.io_addr > `FBX_IO_TOP; // [RQ20]
    assign br_target = pc + {{(PC_W-8){ir.k[7]}}, ir.k} + PC_W'(1); // [RQ1] [RQ21]

    ////////////////////////////////////////////////////////////////////////
    // sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            fbx_pkg::st_idle: begin
                if (start) begin
                    next_state = fbx_pkg::st_exec;
                end
            end
            fbx_pkg::st_exec: begin
                if (br && tk) begin
                    next_state = fbx_pkg::st_branch2; // [RQ1]
                end else if (io_op && !io_bad) begin
                    next_state = fbx_pkg::st_io2; // [RQ9]
                end else begin
                    next_state = fbx_pkg::st_idle;
                end
            end
            fbx_pkg::st_branch2: next_state = fbx_pkg::st_idle;
            fbx_pkg::st_io2:     next_state = fbx_pkg::st_idle;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state    <= fbx_pkg::st_idle;
            o_busy   <= 1'b0;
            last_cyc <= `FBX_CYC_RST;
        end else if (i_ce) begin
            state  <= next_state;
            o_busy <= next_state != fbx_pkg::st_idle;
            if (state == fbx_pkg::st_exec) begin
                last_cyc <= `FBX_CYC_ONE;
            end else if (state != fbx_pkg::st_idle) begin
                last_cyc <= `FBX_CYC_TWO;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            ir <= fbx_pkg::fbx_instr_s'(23'h00_0000);
        end else if (i_ce && start) begin
            ir <= fbx_pkg::fbx_instr_s'(wval[22:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // architectural state
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            pc <= '0;
        end else if (i_ce) begin
            if (sw_wr && !io_hit && i_wb.adr == `FBX_OFF_PC) begin
                pc <= wval[PC_W-1:0];
            end else if (state == fbx_pkg::st_exec && !(br && tk)) begin
                pc <= pc + PC_W'(1); // [RQ1]
            end else if (state == fbx_pkg::st_branch2) begin
                pc <= br_target; // [RQ1]
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            operand <= `FBX_OPER_RST;
            flags   <= `FBX_FLAGS_RST;
        end else if (i_ce) begin
            if (sw_wr && !io_hit && i_wb.adr == `FBX_OFF_OPER) begin
                operand <= wval[7:0];
            end
            if (sw_wr && !io_hit && i_wb.adr == `FBX_OFF_FLAGS) begin
                flags <= wval[7:0];
            end
            if (state == fbx_pkg::st_exec) begin
                operand <= res;
                flags   <= nf;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 32; i++) begin
                io_mem[i] <= `FBX_IO_RST;
            end
        end else if (i_ce) begin
            if (sw_wr && io_hit) begin
                io_mem[i_wb.adr[6:2]] <= wval[7:0];
            end else if (state == fbx_pkg::st_io2) begin
                io_mem[ir.io_addr[4:0]][ir.sel] <= io_val; // [RQ9] [RQ20]
            end
        end
    end

    // out-of-range io address: sticky, write one clears, set wins
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            io_err <= 1'b0;
        end else if (i_ce) begin
            if (state == fbx_pkg::st_exec && io_op && io_bad) begin
                io_err <= 1'b1; // [RQ20]
            end else if (sw_wr && !io_hit && i_wb.adr == `FBX_OFF_STAT
                         && i_wb.sel[0] && i_wb.dat[`FBX_STAT_ERR]) begin
                io_err <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_branch_taken_pc: assert property (@(posedge i_mclk) // [RQ1]
        disable iff (!i_rst_b || !i_ce)
        (state == fbx_pkg::st_exec && br && tk)
        |=> (state == fbx_pkg::st_branch2) ##1 (pc == $past(br_target)))
        else $error("taken branch pc wrong");
    a_branch_untaken: assert property (@(posedge i_mclk) // [RQ1]
        disable iff (!i_rst_b || !i_ce)
        (state == fbx_pkg::st_exec && br && !tk)
        |=> (state == fbx_pkg::st_idle) && (pc == $past(pc) + PC_W'(1)))
        else $error("untaken branch pc wrong");
    a_carry_test: assert property (@(posedge i_mclk) // [RQ2]
        disable iff (!i_rst_b)
        (ir.op == fbx_pkg::op_branch_lower) |-> (tk == flags[`FBX_FLAG_C]))
        else $error("carry branch test wrong");
    a_signed_ge: assert property (@(posedge i_mclk) // [RQ3]
        disable iff (!i_rst_b)
        (ir.op == fbx_pkg::op_branch_signed_ge)
        |-> (tk != (flags[`FBX_FLAG_N] ^ flags[`FBX_FLAG_V])))
        else $error("signed ge test wrong");
    a_branch_flags_kept: assert property (@(posedge i_mclk) // [RQ5]
        disable iff (!i_rst_b || !i_ce)
        (state == fbx_pkg::st_exec && br) |=> $stable(flags))
        else $error("branch changed flags");
    a_io_two_cycle: assert property (@(posedge i_mclk) // [RQ9]
        disable iff (!i_rst_b || !i_ce)
        (state == fbx_pkg::st_exec && io_op && !io_bad)
        |=> (state == fbx_pkg::st_io2) ##1 (state == fbx_pkg::st_idle)
            && (last_cyc == `FBX_CYC_TWO))
        else $error("io bit op not two cycles");
    a_io_range_err: assert property (@(posedge i_mclk) // [RQ20]
        disable iff (!i_rst_b || !i_ce)
        (state == fbx_pkg::st_exec && io_op && io_bad)
        |=> io_err && (state == fbx_pkg::st_idle))
        else $error("io range not refused");
    a_shift_left: assert property (@(posedge i_mclk) // [RQ10]
        disable iff (!i_rst_b || !i_ce)
        (state == fbx_pkg::st_exec && ir.op == fbx_pkg::op_shift_left_logical)
        |=> (operand[7:1] == $past(operand[6:0])) && !operand[0]
            && (flags[`FBX_FLAG_C] == $past(operand[7])))
        else $error("left shift result wrong");
    a_swap_nibbles: assert property (@(posedge i_mclk) // [RQ13]
        disable iff (!i_rst_b || !i_ce)
        (state == fbx_pkg::st_exec && ir.op == fbx_pkg::op_swap_nibbles)
        |=> $stable(flags) && (operand[3:0] == $past(operand[7:4])))
        else $error("nibble swap wrong");

endmodule

// ==== design/fbx_map.svh ====
// register map, field positions, reset values and cycle counts
`ifndef FBX_MAP_SVH
`define FBX_MAP_SVH

`define FBX_OFF_INSTR    8'h00
`define FBX_OFF_OPER     8'h04
`define FBX_OFF_FLAGS    8'h08
`define FBX_OFF_PC       8'h0C
`define FBX_OFF_STAT     8'h10
`define FBX_IO_SEL_BIT   7
`define FBX_IO_TOP       6'h1F

`define FBX_FLAG_C       3'h0
`define FBX_FLAG_Z       3'h1
`define FBX_FLAG_N       3'h2
`define FBX_FLAG_V       3'h3
`define FBX_FLAG_S       3'h4
`define FBX_FLAG_H       3'h5
`define FBX_FLAG_T       3'h6
`define FBX_FLAG_I       3'h7

`define FBX_STAT_BUSY    0
`define FBX_STAT_ERR     1

`define FBX_OPER_RST     8'h00
`define FBX_FLAGS_RST    8'h00
`define FBX_IO_RST       8'h00
`define FBX_CYC_RST      8'h00
`define FBX_CYC_ONE      8'h01
`define FBX_CYC_TWO      8'h02

`endif

// ==== design/fbx_pkg.sv ====
// types for the flag, branch, bit and shift execution unit
package fbx_pkg;

    typedef enum logic [5:0] {
        op_branch_carry_one       = 6'b000000,
        op_branch_carry_zero      = 6'b000001,
        op_branch_same_or_higher  = 6'b000010,
        op_branch_lower           = 6'b000011,
        op_branch_negative_one    = 6'b000100,
        op_branch_negative_zero   = 6'b000101,
        op_branch_signed_ge       = 6'b000110,
        op_branch_signed_lt       = 6'b000111,
        op_branch_halfcarry_one   = 6'b001000,
        op_branch_halfcarry_zero  = 6'b001001,
        op_branch_transfer_one    = 6'b001010,
        op_branch_transfer_zero   = 6'b001011,
        op_branch_overflow_one    = 6'b001100,
        op_branch_overflow_zero   = 6'b001101,
        op_branch_irq_enabled     = 6'b001110,
        op_branch_irq_disabled    = 6'b001111,
        op_branch_flag_bit_one    = 6'b010000,
        op_branch_flag_bit_zero   = 6'b010001,
        op_io_bit_set             = 6'b010010,
        op_io_bit_clear           = 6'b010011,
        op_shift_left_logical     = 6'b010100,
        op_shift_right_logical    = 6'b010101,
        op_rotate_left_carry      = 6'b010110,
        op_rotate_right_carry     = 6'b010111,
        op_shift_right_arith      = 6'b011000,
        op_swap_nibbles           = 6'b011001,
        op_flag_bit_set           = 6'b011010,
        op_flag_bit_clear         = 6'b011011,
        op_reg_bit_to_transfer    = 6'b011100,
        op_transfer_to_reg_bit    = 6'b011101,
        op_set_carry              = 6'b100000,
        op_clr_carry              = 6'b100001,
        op_set_negative           = 6'b100010,
        op_clr_negative           = 6'b100011,
        op_set_zero               = 6'b100100,
        op_clr_zero               = 6'b100101,
        op_set_sign               = 6'b100110,
        op_clr_sign               = 6'b100111,
        op_set_overflow           = 6'b101000,
        op_clr_overflow           = 6'b101001,
        op_set_transfer           = 6'b101010,
        op_clr_transfer           = 6'b101011,
        op_set_halfcarry          = 6'b101100,
        op_clr_halfcarry          = 6'b101101,
        op_irq_global_on          = 6'b101110,
        op_irq_global_off         = 6'b101111
    } fbx_op_e;

    typedef enum logic [1:0] {
        st_idle    = 2'b00,
        st_exec    = 2'b01,
        st_branch2 = 2'b10,
        st_io2     = 2'b11
    } fbx_state_e;

    typedef struct packed {
        logic [5:0] io_addr;
        logic [7:0] k;
        logic [2:0] sel;
        fbx_op_e    op;
    } fbx_instr_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } fbx_wb_req_s;

endpackage

// ==== sim/fbx_exec_bench.sv ====
// self-checking bench for the flag, branch, bit and shift unit
`include "fbx_map.svh"
`define CMP(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module fbx_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 i_mclk = 1'b0;
    logic                 i_rst_b = 1'b0;
    logic                 i_ce = 1'b1;
    fbx_pkg::fbx_wb_req_s i_wb = '0;
    logic                 o_wb_ack;
    logic [31:0]          o_wb_dat;
    logic                 o_busy;
    int                   fails = 0;
    int                   comparisons = 0;
    int                   seed = 4413;
    int                   e_cyc;
    int                   cnt;
    logic [32:0]          notes[$];
    logic [32:0]          note;
    logic [7:0]           e_op;
    logic [7:0]           e_fl;
    logic [7:0]           io_m[32];
    logic [15:0]          e_pc = 16'h0000;
    logic                 e_err;

    fbx_exec #(.PC_W(16)) DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_ce(i_ce), .i_wb(i_wb), .o_wb_ack(o_wb_ack),
        .o_wb_dat(o_wb_dat), .o_busy(o_busy));

    always #5 i_mclk = ~i_mclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat, input logic [31:0] exp);
        int n;
        n = 0;
        notes.push_back({~we, exp});
        @(posedge i_mclk);
        i_wb <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hF, adr:adr, dat:dat};
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        i_wb.cyc <= 1'b0;
        i_wb.stb <= 1'b0;
        if (n >= 20) fails++;
    endtask

    task automatic model(input logic [5:0] op, input logic [2:0] s,
                         input logic [7:0] k, input logic [5:0] io);
        logic v;
        logic c;
        logic [2:0] f;
        e_cyc = 1;
        e_err = 1'b0;
        e_pc = e_pc + 16'h0001;
        c = e_fl[0];
        if (op <= 6'h11) begin
            case (op[4:1])
                4'h0: v = e_fl[0];
                4'h1: v = ~e_fl[0];
                4'h2: v = e_fl[2];
                4'h3: v = ~(e_fl[2] ^ e_fl[3]);
                4'h4: v = e_fl[5];
                4'h5: v = e_fl[6];
                4'h6: v = e_fl[3];
                4'h7: v = e_fl[7];
                default: v = e_fl[s];
            endcase
            if (v ^ op[0]) begin
                e_pc = e_pc + {{8{k[7]}}, k};
                e_cyc = 2;
            end
        end else if (op == 6'h12 || op == 6'h13) begin
            if (io <= `FBX_IO_TOP) begin
                io_m[io][s] = ~op[0];
                e_cyc = 2;
            end else begin
                e_err = 1'b1;
            end
        end else if (op <= 6'h18) begin
            case (op)
                6'h14: {c, e_op} = {e_op, 1'b0};
                6'h15: {e_op, c} = {1'b0, e_op};
                6'h16: {c, e_op} = {e_op, e_fl[0]};
                6'h17: {e_op, c} = {e_fl[0], e_op};
                default: {e_op, c} = {e_op[7], e_op};
            endcase
            e_fl[3:0] = {e_op[7] ^ c, e_op[7], e_op == 8'h00, c};
        end else if (op == 6'h19) begin
            e_op = {e_op[3:0], e_op[7:4]};
        end else if (op == 6'h1A || op == 6'h1B) begin
            e_fl[s] = ~op[0];
        end else if (op == 6'h1C) begin
            e_fl[6] = e_op[s];
        end else if (op == 6'h1D) begin
            e_op[s] = e_fl[6];
        end else if (op >= 6'h20) begin
            f = 3'(24'hF73850 >> (3 * op[3:1]));
            e_fl[f] = ~op[0];
        end
    endtask

    task automatic run(input logic [5:0] op);
        logic [2:0] s;
        logic [7:0] k;
        logic [5:0] io;
        s = 3'($random(seed));
        k = 8'($random(seed));
        io = 6'($random(seed));
        e_op = 8'($random(seed));
        e_fl = 8'($random(seed));
        bus(1'b1, `FBX_OFF_STAT, 32'h0000_0002, 32'h0);
        bus(1'b1, `FBX_OFF_OPER, {24'h0, e_op}, 32'h0);
        bus(1'b1, `FBX_OFF_FLAGS, {24'h0, e_fl}, 32'h0);
        model(op, s, k, io);
        bus(1'b1, `FBX_OFF_INSTR, {9'h0, io, k, s, op}, 32'h0);
        cnt = 0;
        while (o_busy === 1'b1 && cnt < 9) begin
            @(posedge i_mclk);
            cnt++;
        end
        `CMP(cnt, e_cyc)
        bus(1'b0, `FBX_OFF_OPER, {24'h0, e_op}, {24'h0, e_op});
        bus(1'b0, `FBX_OFF_FLAGS, 32'h0, {24'h0, e_fl});
        bus(1'b0, `FBX_OFF_PC, 32'h0, {16'h0, e_pc});
        bus(1'b0, `FBX_OFF_STAT, 32'h0,
            {16'h0, 8'(e_cyc), 6'h0, e_err, 1'b0});
        if (op == 6'h12 || op == 6'h13) begin
            bus(1'b0, 8'h80 + {io[4:0], 2'b00}, 32'h0,
                {24'h0, io_m[io[4:0]]});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_mclk) begin
        if (o_wb_ack === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            if (note[32]) `CMP(o_wb_dat, note[31:0])
        end
    end

    initial begin
        for (int i = 0; i < 32; i++) io_m[i] = 8'h00;
        repeat (6) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        bus(1'b0, `FBX_OFF_FLAGS, 32'h0, 32'h0);
        bus(1'b0, `FBX_OFF_PC, 32'h0, 32'h0);
        bus(1'b0, 8'h14, 32'h0, 32'h0);
        bus(1'b0, 8'h80, 32'h0, 32'h0);
        for (int r = 0; r < 4; r++) begin
            for (int op = 0; op < 48; op++) run(6'(op));
        end
        end_sim;
    end

    initial begin
        #400000;
        fails++;
        end_sim;
    end
endmodule
